// file: src/rsb_pkg.sv
package rsb_pkg;
   // Core clock and loss-of-signal limit
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TIMEOUT_MS = 100;
   // Longest time, so the division rounds down
   localparam int unsigned TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

   // Bus level seen by the comparators
   typedef enum logic [1:0] {LVL_IDLE, LVL_HIGH, LVL_LOW} level_t;

   // Word lengths and layout, first bit received is the MSB
   localparam logic [4:0] SHORT_BITS = 5'h0C;
   localparam logic [4:0] LONG_BITS = 5'h14;
   localparam int unsigned CMD_LSB = 4;
   localparam int unsigned ADDR_LSB = 8;
   localparam int unsigned DATA_LSB = 12;
   localparam logic [4:0] CRC_SPAN_LONG = 5'h10;
   localparam logic [4:0] CRC_SPAN_SHORT = 5'h08;

   // Frame check sequence
   localparam logic [3:0] CRC_POLY = 4'h3;
   localparam logic [3:0] CRC_SEED = 4'hA;

   // Command codes
   localparam logic [3:0] CMD_INIT = 4'h0;
   localparam logic [3:0] CMD_STATUS = 4'h1;
   localparam logic [3:0] CMD_VALUE0 = 4'h2;
   localparam logic [3:0] CMD_IO_CTRL = 4'h3;
   localparam logic [3:0] CMD_ID = 4'h4;
   localparam logic [3:0] CMD_VALUE1 = 4'h5;
   localparam logic [3:0] CMD_VALUE2 = 4'h6;
   localparam logic [3:0] CMD_CLEAR = 4'h7;
   localparam logic [3:0] CMD_VALUE3 = 4'h8;
   localparam logic [3:0] CMD_NVM = 4'h9;
   localparam logic [3:0] CMD_LO_CLEAR = 4'hC;
   localparam logic [3:0] CMD_LO_SET = 4'hD;
   localparam logic [3:0] CMD_REV_INIT = 4'hF;

   // Initialization data byte fields
   localparam int unsigned NV_BIT = 7;
   localparam int unsigned CLOSE_BIT = 6;

   // Reset values and fixed response values
   localparam logic [3:0] ADDR_RESET = 4'h0;
   localparam logic [7:0] ADC_ERROR = 8'h00;
   localparam logic [7:0] ADC_ZERO_SUB = 8'h01;
   localparam logic [4:0] ID_LOW = 5'h03;
   localparam logic [3:0] NVM_MARK = 4'hF;
endpackage

// file: src/remote_sensor_bus_slave.sv
`timescale 1ns/1ps
`default_nettype none
module remote_sensor_bus_slave #(
   parameter int unsigned TIMEOUT_CYCLES_P = rsb_pkg::TIMEOUT_CYCLES,
   parameter int unsigned PHASE_W = 16,
   parameter logic [2:0] VERSION = 3'h1 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic up_above_low,
   input wire logic up_at_idle,
   input wire logic down_above_low,
   input wire logic down_at_idle,
   input wire logic undervoltage,
   input wire logic [3:0] gpio_in,
   input wire logic preprog_mode,
   input wire logic [3:0] preprog_addr,
   input wire logic adc_done,
   input wire logic adc_valid,
   input wire logic [7:0] adc_data,
   output logic upstream_current_en,
   output logic downstream_current_en,
   output logic downstream_present,
   output logic downstream_pass_switch,
   output logic high_drive_logic_output,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   output logic adc_start,
   output logic [1:0] adc_channel,
   output logic timeout_reset
);
   import rsb_pkg::*;

   typedef enum logic [1:0] {D_IDLE, D_START, D_LOW, D_HIGH} dec_t;

   // Comparator pair to bus level
   function automatic level_t lvl_of(input logic above_low, input logic idle);
      if (idle)
         return LVL_IDLE;
      return above_low ? LVL_HIGH : LVL_LOW;
   endfunction

   // Serial CRC over the n least significant bits, MSB first
   function automatic logic [3:0] crc4(input logic [15:0] d,
                                      input logic [4:0] n);
      logic [3:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 15; i >= 0; i--) begin
         if (i < int'(n)) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'b0};
            if (fb)
               c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction

   logic timeout_reg;
   logic srst;
   logic [8:0] sync1_reg, sync2_reg;
   level_t up_lvl, down_lvl, cur_lvl, prev_reg;
   logic up_act, down_act;
   dec_t dec_reg;
   logic [PHASE_W-1:0] low_cnt_reg, high_cnt_reg;
   logic [19:0] rx_reg;
   logic [4:0] nbits_reg;
   logic word_done_reg, from_down_reg, down_present_reg;
   logic [31:0] idle_cnt_reg;
   logic bit_val, frame_start, fall_edge;
   logic [19:0] tx_reg;
   logic [4:0] tx_cnt_reg;
   logic current_reg;
   logic [3:0] addr_reg, gpio_out_reg, gpio_oe_reg;
   logic strap_done_reg, inited_reg, switch_reg, nv_reg, lo_reg, uv_reg;
   logic [1:0] group_reg;
   logic resp_pend_reg, resp_long_reg;
   logic [3:0] resp_cmd_reg;
   logic [7:0] value_reg;
   logic adc_start_reg;
   logic [1:0] adc_chan_reg;
   logic [19:0] wd;
   logic len_ok, is_long, crc_ok, good, addr_hit, init_ok;
   logic [3:0] w_addr, w_cmd, w_crc;
   logic [7:0] w_data, resp8;
   logic [15:0] payload;

   assign srst = !rst_b || timeout_reg;

   // Flush value reads as an idle bus, so no false word follows reset
   localparam logic [8:0] SYNC_IDLE = 9'h00F;

   // Comparators, pins and supply monitor are asynchronous
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync1_reg <= SYNC_IDLE;
         sync2_reg <= SYNC_IDLE;
      end else begin
         sync1_reg <= {undervoltage, gpio_in, down_at_idle, down_above_low,
                       up_at_idle, up_above_low};
         sync2_reg <= sync1_reg;
      end
   end

   // Either pin may carry the waveform; upstream wins if both do
   assign up_lvl = lvl_of(sync2_reg[0], sync2_reg[1]);
   assign down_lvl = lvl_of(sync2_reg[2], sync2_reg[3]);
   assign up_act = (up_lvl != LVL_IDLE);
   assign down_act = (down_lvl != LVL_IDLE);
   assign cur_lvl = up_act ? up_lvl : down_lvl;
   assign fall_edge = (prev_reg == LVL_HIGH) && (cur_lvl == LVL_LOW);
   assign frame_start = (prev_reg == LVL_IDLE) && (cur_lvl != LVL_IDLE);
   assign bit_val = (high_cnt_reg > low_cnt_reg);

   // Loss-of-signal timer; its own reset is the pin reset or its own timeout
   always_ff @(posedge core_clk) begin
      if (!rst_b || timeout_reg) begin
         idle_cnt_reg <= 32'h0000_0000;
         timeout_reg <= 1'b0;
      end else if (cur_lvl == LVL_IDLE) begin
         idle_cnt_reg <= 32'h0000_0000;
      end else if (idle_cnt_reg >= TIMEOUT_CYCLES_P - 1) begin
         timeout_reg <= 1'b1;
      end else begin
         idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
      end
   end

   // Word decoder; ratio of phases, not absolute time, sets each bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dec_reg <= D_IDLE;
         prev_reg <= LVL_IDLE;
         low_cnt_reg <= '0;
         high_cnt_reg <= '0;
         rx_reg <= 20'h0_0000;
         nbits_reg <= 5'h00;
         word_done_reg <= 1'b0;
         from_down_reg <= 1'b0;
         down_present_reg <= 1'b0;
      end else begin
         prev_reg <= cur_lvl;
         word_done_reg <= 1'b0;
         down_present_reg <= down_act;
         unique case (dec_reg)
            D_IDLE: if (cur_lvl != LVL_IDLE) begin
               dec_reg <= D_START;
               from_down_reg <= !up_act;
               nbits_reg <= 5'h00;
               low_cnt_reg <= '0;
               high_cnt_reg <= '0;
            end
            D_START: if (cur_lvl == LVL_LOW)
               dec_reg <= D_LOW;
            else if (cur_lvl == LVL_IDLE)
               dec_reg <= D_IDLE;
            D_LOW: if (cur_lvl == LVL_HIGH)
               dec_reg <= D_HIGH;
            else if (cur_lvl == LVL_IDLE)
               dec_reg <= D_IDLE; // Malformed, dropped
            else if (~&low_cnt_reg)
               low_cnt_reg <= low_cnt_reg + 1'b1;
            D_HIGH: if (cur_lvl == LVL_HIGH) begin
               if (~&high_cnt_reg)
                  high_cnt_reg <= high_cnt_reg + 1'b1;
            end else begin
               rx_reg <= {rx_reg[18:0], bit_val};
               if (~&nbits_reg)
                  nbits_reg <= nbits_reg + 5'h01;
               low_cnt_reg <= '0;
               high_cnt_reg <= '0;
               dec_reg <= (cur_lvl == LVL_IDLE) ? D_IDLE : D_LOW;
               word_done_reg <= (cur_lvl == LVL_IDLE);
            end
         endcase
      end
   end

   // Received word check
   assign is_long = (nbits_reg == LONG_BITS);
   assign len_ok = is_long || (nbits_reg == SHORT_BITS);
   assign wd = is_long ? rx_reg : {8'h00, rx_reg[11:0]};
   assign w_crc = wd[3:0];
   assign w_cmd = wd[CMD_LSB +: 4];
   assign w_addr = wd[ADDR_LSB +: 4];
   assign w_data = wd[DATA_LSB +: 8];
   assign crc_ok = is_long ? (crc4(wd[19:4], CRC_SPAN_LONG) == w_crc)
                           : (crc4({8'h00, wd[11:4]}, CRC_SPAN_SHORT) == w_crc);
   assign good = word_done_reg && len_ok && crc_ok;
   assign addr_hit = (w_addr == addr_reg);
   // Unaddressed parts take any address; preprogrammed need a match
   assign init_ok = preprog_mode ? (w_data[3:0] == addr_reg)
                                 : (addr_reg == ADDR_RESET && !inited_reg);

   // Command execution at the end of a clean word
   always_ff @(posedge core_clk) begin
      if (srst) begin
         addr_reg <= ADDR_RESET;
         switch_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         inited_reg <= 1'b0;
         nv_reg <= 1'b0;
         group_reg <= 2'h0;
         gpio_out_reg <= 4'h0;
         gpio_oe_reg <= 4'h0;
         lo_reg <= 1'b0;
         resp_pend_reg <= 1'b0;
         resp_long_reg <= 1'b0;
         resp_cmd_reg <= CMD_INIT;
         adc_start_reg <= 1'b0;
         adc_chan_reg <= 2'h0;
      end else begin
         adc_start_reg <= 1'b0;
         strap_done_reg <= 1'b1;
         if (!strap_done_reg && preprog_mode)
            addr_reg <= preprog_addr;
         if (frame_start)
            resp_pend_reg <= 1'b0;
         if (good) begin
            resp_cmd_reg <= w_cmd;
            resp_long_reg <= is_long;
            unique case (w_cmd)
               CMD_INIT, CMD_REV_INIT: begin
                  // reverse form needs downstream signal, uninit part
                  if (is_long && init_ok && (w_cmd == CMD_INIT ?
                      !from_down_reg : (from_down_reg && !inited_reg))) begin
                     addr_reg <= w_data[3:0];
                     inited_reg <= 1'b1;
                     nv_reg <= w_data[NV_BIT];
                     group_reg <= w_data[5:4];
                     switch_reg <= w_data[CLOSE_BIT];
                     resp_pend_reg <= 1'b1;
                  end
               end
               CMD_IO_CTRL: if (is_long && addr_hit) begin
                  gpio_out_reg <= w_data[7:4];
                  gpio_oe_reg <= w_data[3:0];
                  resp_pend_reg <= 1'b1;
               end
               CMD_CLEAR: if (addr_hit)
                  gpio_oe_reg <= 4'h0;
               CMD_VALUE0, CMD_VALUE1, CMD_VALUE2, CMD_VALUE3:
                  if (addr_hit) begin
                     adc_start_reg <= 1'b1;
                     adc_chan_reg <= (w_cmd == CMD_VALUE0) ? 2'h0 :
                                     (w_cmd == CMD_VALUE1) ? 2'h1 :
                                     (w_cmd == CMD_VALUE2) ? 2'h2 : 2'h3;
                     resp_pend_reg <= 1'b1;
                  end
               CMD_LO_CLEAR, CMD_LO_SET: if (addr_hit) begin
                  lo_reg <= (w_cmd == CMD_LO_SET);
                  resp_pend_reg <= 1'b1;
               end
               CMD_STATUS, CMD_ID: if (addr_hit)
                  resp_pend_reg <= 1'b1;
               CMD_NVM: if (is_long && addr_hit)
                  resp_pend_reg <= 1'b1;
               default: ; // Reserved codes are ignored
            endcase
         end
      end
   end

   // Conversion capture; 00 is kept for errors
   always_ff @(posedge core_clk) begin
      if (srst)
         value_reg <= ADC_ERROR;
      else if (adc_start_reg)
         value_reg <= ADC_ERROR; // Unfinished conversion reads invalid
      else if (adc_done) begin
         if (!adc_valid || sync2_reg[8])
            value_reg <= ADC_ERROR;
         else if (adc_data == ADC_ERROR)
            value_reg <= ADC_ZERO_SUB;
         else
            value_reg <= adc_data;
      end
   end

   // Undervoltage latch; a new event beats the read clear
   always_ff @(posedge core_clk) begin
      if (srst)
         uv_reg <= 1'b0;
      else if (sync2_reg[8])
         uv_reg <= 1'b1;
      else if (frame_start && resp_pend_reg && resp_cmd_reg == CMD_STATUS)
         uv_reg <= 1'b0;
   end

   // Response payload from the latched command
   always_comb begin
      unique case (resp_cmd_reg)
         CMD_INIT, CMD_REV_INIT: resp8 = {nv_reg, switch_reg, group_reg,
                                          addr_reg};
         CMD_STATUS, CMD_LO_CLEAR, CMD_LO_SET:
            resp8 = {nv_reg, uv_reg, lo_reg, switch_reg, sync2_reg[7:4]};
         CMD_IO_CTRL: resp8 = {gpio_out_reg, gpio_oe_reg};
         CMD_ID: resp8 = {VERSION, ID_LOW};
         CMD_NVM: resp8 = {NVM_MARK, addr_reg};
         default: resp8 = value_reg;
      endcase
      payload = resp_long_reg ? {addr_reg, 4'h0, resp8} : {8'h00, resp8};
   end

   // Encoder: loaded at the next message, one bit per high-to-low
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_reg <= 20'h0_0000;
         tx_cnt_reg <= 5'h00;
         current_reg <= 1'b0;
      end else if (cur_lvl == LVL_IDLE) begin
         tx_cnt_reg <= 5'h00;
         current_reg <= 1'b0;
      end else if (frame_start) begin
         tx_cnt_reg <= resp_pend_reg ? (resp_long_reg ? LONG_BITS
                                                      : SHORT_BITS) : 5'h00;
         tx_reg <= resp_long_reg ? {payload, crc4(payload, CRC_SPAN_LONG)}
                                 : {payload[7:0], crc4(payload,
                                    CRC_SPAN_SHORT), 8'h00};
      end else if (fall_edge) begin
         current_reg <= (tx_cnt_reg != 5'h00) && tx_reg[19];
         tx_reg <= {tx_reg[18:0], 1'b0};
         if (tx_cnt_reg != 5'h00)
            tx_cnt_reg <= tx_cnt_reg - 5'h01;
      end
   end

   assign upstream_current_en = current_reg;
   assign downstream_current_en = current_reg;
   assign downstream_present = down_present_reg;
   assign downstream_pass_switch = switch_reg;
   assign high_drive_logic_output = lo_reg;
   assign gpio_out = gpio_out_reg;
   assign gpio_oe = gpio_oe_reg;
   assign adc_start = adc_start_reg;
   assign adc_channel = adc_chan_reg;
   assign timeout_reset = timeout_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_low_fall;
      cur_lvl != LVL_IDLE ##1 cur_lvl == LVL_IDLE;
   endsequence
   sequence s_bit_out;
      fall_edge && tx_cnt_reg != 5'h00 && tx_reg[19];
   endsequence

   chk_timeout_fires: assert property (
      idle_cnt_reg >= TIMEOUT_CYCLES_P - 1 && cur_lvl != LVL_IDLE
      |=> timeout_reg) else $error("timeout did not reset part");
   chk_uv_latch: assert property (
      sync2_reg[8] |=> uv_reg) else $error("undervoltage not latched");
   chk_adc_low_supply: assert property (
      adc_done && !adc_start_reg && sync2_reg[8] |=> value_reg == ADC_ERROR)
      else $error("low supply value not zero");
   chk_adc_invalid: assert property (
      adc_done && !adc_start_reg && !adc_valid |=> value_reg == ADC_ERROR)
      else $error("invalid conversion not flagged");
   chk_zero_sub: assert property (
      adc_done && !adc_start_reg && adc_valid && !sync2_reg[8]
      && adc_data == ADC_ERROR |=> value_reg == ADC_ZERO_SUB)
      else $error("zero result not replaced");
   chk_current_idle: assert property (
      s_low_fall |=> !current_reg) else $error("current on at idle");
   chk_bit_present: assert property (
      s_bit_out |=> current_reg ##0 $stable(resp_long_reg))
      else $error("response bit not presented");
   chk_bad_len_drop: assert property (
      word_done_reg && !len_ok |=> $stable(gpio_oe_reg) && $stable(addr_reg)
      && $stable(lo_reg)) else $error("bad word caused action");
   chk_rev_init_gate: assert property (
      good && w_cmd == CMD_REV_INIT && inited_reg
      |=> $stable(addr_reg) && $stable(switch_reg))
      else $error("reverse init acted while initialized");
   chk_io_dir: assert property (
      good && w_cmd == CMD_IO_CTRL && is_long && addr_hit
      |=> gpio_oe_reg == $past(w_data[3:0])) else $error("direction not set");
endmodule
`default_nettype wire

// file: dv/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Central master: sends pulse-width coded words, reads back load current
module bus_master_model #(
   parameter int unsigned T = 6
) (
   input wire logic core_clk,
   input wire logic current_en,
   output logic up_above_low,
   output logic up_at_idle,
   output logic down_above_low,
   output logic down_at_idle,
   output logic resp_valid,
   output logic [19:0] resp_word
);
   import rsb_pkg::*;
   level_t lvl = LVL_IDLE;
   logic on_down = 1'b0;
   initial resp_valid = 1'b0;
   initial resp_word = 20'h00000;

   // The pin not in use rests at idle, as an open link end would
   always_comb begin
      up_at_idle = on_down || lvl == LVL_IDLE;
      up_above_low = on_down || lvl != LVL_LOW;
      down_at_idle = !on_down || lvl == LVL_IDLE;
      down_above_low = !on_down || lvl != LVL_LOW;
   end

   task automatic phase(input level_t l, input int n);
      lvl <= l;
      repeat (n) @(posedge core_clk);
   endtask

   // Word: idle, high, then low-high per bit, back to idle at the end
   task automatic send(input logic [19:0] w, input int nb, input logic dn,
                       input int nr);
      logic [19:0] r;
      r = 20'h00000;
      on_down <= dn;
      phase(LVL_HIGH, T);
      for (int i = nb - 1; i >= 0; i--) begin
         phase(LVL_LOW, w[i] ? T : 2 * T);
         // Late in the low phase the presented bit has long settled
         if (nb - 1 - i < nr) r = {r[18:0], current_en};
         phase(LVL_HIGH, w[i] ? 2 * T : T);
      end
      phase(LVL_IDLE, 12);
      if (nr > 0) begin
         resp_valid <= 1'b1;
         resp_word <= r;
         @(posedge core_clk);
         resp_valid <= 1'b0;
      end
   endtask

   // Bus stuck at the low level, out of idle, as after a lost master
   task automatic hold(input int n);
      phase(LVL_LOW, n);
      phase(LVL_IDLE, 12);
   endtask
endmodule
`default_nettype wire

// file: dv/remote_sensor_bus_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module remote_sensor_bus_slave_tb;
   import rsb_pkg::*;
   // Short limit keeps the run brief; still above the longest word
   localparam int unsigned TMO = 600;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic up_above_low, up_at_idle, down_above_low, down_at_idle;
   logic undervoltage = 1'b0;
   logic [3:0] gpio_in = 4'h5;
   logic preprog_mode = 1'b0;
   logic [3:0] preprog_addr = 4'h6;
   logic adc_done = 1'b0;
   logic adc_valid = 1'b0;
   logic [7:0] adc_data = 8'h00;
   logic up_cur, dn_cur, dn_present, pass_sw, lo_out, adc_start, tmo;
   logic [3:0] gpio_out, gpio_oe;
   logic [1:0] adc_channel;
   logic [19:0] resp_word;
   logic resp_valid;
   int errors = 0;
   int n_checks = 0;
   int n_tmo = 0;
   logic seen_down = 1'b0;
   logic [7:0] lfsr = 8'h03;
   logic [7:0] e;
   logic [19:0] exp_resp[$];
   logic [1:0] exp_chan[$];
   logic [3:0] vcmd[4] = '{CMD_VALUE0, CMD_VALUE1, CMD_VALUE2, CMD_VALUE3};

   always #12.5 core_clk = ~core_clk;

   remote_sensor_bus_slave #(.TIMEOUT_CYCLES_P(TMO)) dut (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .up_above_low(up_above_low),
      .up_at_idle(up_at_idle),
      .down_above_low(down_above_low),
      .down_at_idle(down_at_idle),
      .undervoltage(undervoltage),
      .gpio_in(gpio_in),
      .preprog_mode(preprog_mode),
      .preprog_addr(preprog_addr),
      .adc_done(adc_done),
      .adc_valid(adc_valid),
      .adc_data(adc_data),
      .upstream_current_en(up_cur),
      .downstream_current_en(dn_cur),
      .downstream_present(dn_present),
      .downstream_pass_switch(pass_sw),
      .high_drive_logic_output(lo_out),
      .gpio_out(gpio_out),
      .gpio_oe(gpio_oe),
      .adc_start(adc_start),
      .adc_channel(adc_channel),
      .timeout_reset(tmo)
   );

   bus_master_model m (
      .core_clk(core_clk),
      .current_en(up_cur),
      .up_above_low(up_above_low),
      .up_at_idle(up_at_idle),
      .down_above_low(down_above_low),
      .down_at_idle(down_at_idle),
      .resp_valid(resp_valid),
      .resp_word(resp_word)
   );

   task automatic fail(input string s);
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, s);
   endtask
   task automatic cmp_resp(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("response %h, want %h", got, exp));
   endtask
   task automatic cmp_chan(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("channel %h, want %h", got, exp));
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("port value %h, want %h", got, exp));
   endtask

   // Scoreboard: each result that shows up meets the oldest note
   always @(posedge core_clk) begin
      if (resp_valid === 1'b1) begin
         if (exp_resp.size() == 0) fail("response without a note");
         else cmp_resp(resp_word, exp_resp.pop_front());
      end
      if (adc_start === 1'b1) begin
         if (exp_chan.size() == 0) fail("conversion without a note");
         else cmp_chan(adc_channel, exp_chan.pop_front());
      end
      if (tmo === 1'b1) n_tmo++;
      if (dn_present === 1'b1) seen_down <= 1'b1;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Check nibble, MSB first over the low n bits
   function automatic logic [3:0] crc4(input logic [15:0] v, input int n);
      logic [3:0] c;
      c = CRC_SEED;
      for (int i = n - 1; i >= 0; i--)
         c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? CRC_POLY : 4'h0);
      return c;
   endfunction
   function automatic logic [19:0] lw(input logic [3:0] c,
                                      input logic [3:0] a,
                                      input logic [7:0] d);
      return {d, a, c, crc4({d, a, c}, 16)};
   endfunction
   function automatic logic [19:0] sw(input logic [3:0] c,
                                      input logic [3:0] a);
      return {8'h00, a, c, crc4({8'h00, a, c}, 8)};
   endfunction
   function automatic logic [19:0] rs(input logic [7:0] d);
      return {8'h00, d, crc4({8'h00, d}, 8)};
   endfunction

   task automatic tx(input logic [19:0] w, input int nb, input logic dn);
      m.send(w, nb, dn, 0);
   endtask
   // Answers come in the next word, so a filler to a foreign address reads it
   task automatic query(input logic [19:0] w, input int nb,
                        input logic [19:0] x);
      m.send(w, nb, 1'b0, 0);
      exp_resp.push_back(x);
      m.send(nb == 20 ? lw(CMD_STATUS, 4'hE, 8'h00) : sw(CMD_STATUS, 4'hE),
             nb, 1'b0, nb);
      chk(8'({up_cur, dn_cur}), 8'h00);
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic complete_run;
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      do_reset;
      chk(8'({pass_sw, gpio_oe}), 8'h00);
      tx(lw(CMD_REV_INIT, 4'h0, 8'h49), 20, 1'b0);
      chk(8'(pass_sw), 8'h00);
      tx(lw(CMD_INIT, 4'h0, 8'h45), 20, 1'b0);
      chk(8'({seen_down, pass_sw}), 8'h01);
      tx(lw(CMD_IO_CTRL, 4'h5, 8'hA3) ^ 20'h00001, 20, 1'b0);
      tx(lw(CMD_IO_CTRL, 4'h5, 8'hA3), 16, 1'b0);
      chk(8'(gpio_oe), 8'h00);
      query(lw(CMD_IO_CTRL, 4'h5, 8'hA3), 20,
            {8'h50, 8'hA3, crc4(16'h50A3, 16)});
      chk({gpio_oe, gpio_out & gpio_oe}, 8'h32);
      tx(sw(CMD_LO_SET, 4'h5), 12, 1'b0);
      chk(8'(lo_out), 8'h01);
      undervoltage <= 1'b1;
      repeat (6) @(posedge core_clk);
      undervoltage <= 1'b0;
      query(sw(CMD_STATUS, 4'h5), 12, rs(8'h75));
      query(sw(CMD_STATUS, 4'h5), 12, rs(8'h35));
      query(sw(CMD_LO_CLEAR, 4'h5), 12, rs(8'h15));
      chk(8'(lo_out), 8'h00);
      // Version field is the default of 1
      query(sw(CMD_ID, 4'h5), 12, rs({3'h1, ID_LOW}));
      query(lw(CMD_NVM, 4'h5, 8'hF5), 20,
            {8'h50, 8'hF5, crc4(16'h50F5, 16)});
      // Good value, converter zero, not valid, supply low
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         exp_chan.push_back(2'(i));
         tx(sw(vcmd[i], 4'h5), 12, 1'b0);
         undervoltage <= (i == 3);
         repeat (3) @(posedge core_clk);
         adc_done <= 1'b1;
         adc_valid <= (i != 2);
         adc_data <= (i == 1) ? 8'h00 : lfsr;
         @(posedge core_clk);
         adc_done <= 1'b0;
         undervoltage <= 1'b0;
         e = (i == 1) ? ADC_ZERO_SUB : (i >= 2) ? ADC_ERROR : lfsr;
         exp_resp.push_back(rs(e));
         m.send(sw(CMD_STATUS, 4'hE), 12, 1'b0, 12);
      end
      tx(sw(CMD_CLEAR, 4'h5), 12, 1'b0);
      chk(8'(gpio_oe), 8'h00);
      m.hold(TMO - 50);
      chk(8'({n_tmo[0], pass_sw}), 8'h01);
      m.hold(TMO + 100);
      chk(8'({n_tmo[1:0], pass_sw}), 8'h02);
      tx(lw(CMD_REV_INIT, 4'h0, 8'h49), 20, 1'b1);
      chk(8'({seen_down, pass_sw}), 8'h03);
      preprog_mode <= 1'b1;
      do_reset;
      tx(lw(CMD_INIT, 4'h0, 8'h43), 20, 1'b0);
      chk(8'(pass_sw), 8'h00);
      tx(lw(CMD_INIT, 4'h0, 8'h46), 20, 1'b0);
      chk(8'(pass_sw), 8'h01);
      // Address matches, so only the initialized state may block it
      tx(lw(CMD_REV_INIT, 4'h0, 8'h06), 20, 1'b1);
      chk(8'(pass_sw), 8'h01);
      chk(8'(exp_resp.size() + exp_chan.size()), 8'h00);
      complete_run;
   end

   // Watchdog, well beyond the expected length of the run
   initial begin
      repeat (40000) @(posedge core_clk);
      fail("run did not finish");
      complete_run;
   end
endmodule
`default_nettype wire
